// ### pdf_regs.vh
`ifndef PDF_REGS_VH
`define PDF_REGS_VH
// ==========================================
// register offsets
`define PDF_CTRL_OFS 8'h00
`define PDF_STAT_OFS 8'h04
`define PDF_FSRC_OFS 8'h0C
`define PDF_WEX_OFS 8'h14
`define PDF_DRV_OFS 8'h18
// ==========================================
// reset values
`define PDF_CTRL_RST 32'h00000000
`define PDF_FSRC_RST 32'h00000000
`define PDF_WEX_RST 32'h00000000
`define PDF_DRV_RST 32'h00000000
// ==========================================
// writable bit masks
`define PDF_CTRL_MASK 32'h00000001
`define PDF_FSRC_MASK 32'h00000003
`define PDF_WEX_MASK 32'hFFFF0F03
`define PDF_DRV_MASK 32'hFFFFFFFF
// ==========================================
// field positions
`define PDF_CTRL_EN 0
`define PDF_FSRC_LSB 0
`define PDF_WEX_DEAD_TIME_HIGH_SIDE_MSB 31
`define PDF_WEX_DEAD_TIME_HIGH_SIDE_LSB 24
`define PDF_WEX_DEAD_TIME_LOW_SIDE_MSB 23
`define PDF_WEX_DEAD_TIME_LOW_SIDE_LSB 16
`define PDF_WEX_DTEN_LSB 8
`define PDF_WEX_ROUTE_LSB 0
`define PDF_DRV_FLT1_LSB 28
`define PDF_DRV_FLT0_LSB 24
`define PDF_DRV_INV_LSB 16
`define PDF_DRV_LVL_LSB 8
`define PDF_DRV_OVR_LSB 0
`define PDF_STAT_HF0 0
`define PDF_STAT_HF1 1
`define PDF_STAT_RF 2
`define PDF_STAT_ALT 3
`define PDF_STAT_EN 4
// ==========================================
// fault source codes
`define PDF_SRC_OFF 2'h0
`define PDF_SRC_DIRECT 2'h1
`define PDF_SRC_INVERT 2'h2
`define PDF_SRC_ALT 2'h3
`endif

// ### pdf_filter.v
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// fault input filter: output follows the input only after
// the input has differed from it for filterVal samples in a row
module pdf_filter (
  input wire ref_clk,
  input wire rst,
  input wire sampleIn,
  input wire [3:0] filterVal,
  output reg filtOut
);
  reg [3:0] cnt_reg;

  // a zero filter value passes the sample straight through
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 4'h0;
      filtOut <= 1'b0;
    end else if (filterVal == 4'h0) begin
      cnt_reg <= 4'h0;
      filtOut <= sampleIn;
    end else if (sampleIn == filtOut) begin
      cnt_reg <= 4'h0; // a glitch restarts the count
    end else if (cnt_reg == filterVal - 4'h1) begin
      cnt_reg <= 4'h0;
      filtOut <= sampleIn;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
endmodule
`default_nettype wire

// ### pdf_driver.v
`timescale 1ns/100ps
`default_nettype none
`include "pdf_regs.vh"
module pdf_driver (
  input wire ref_clk,
  input wire rst,
  input wire [7:0] regAddr,
  input wire [31:0] regWdata,
  input wire regWrite,
  input wire regRead,
  output reg [31:0] regRdata,
  input wire [3:0] compareIn,
  input wire periodEnd,
  input wire matchEventIn,
  input wire altFaultIn,
  input wire timerEventIn0,
  input wire timerEventIn1,
  output reg [7:0] waveOut,
  output reg softFault,
  output reg hardFault,
  output reg timerEnable
);
  // ==========================================
  // register storage
  reg [31:0] waveform_extension_control_reg;
  reg [31:0] output_driver_control_reg;
  reg [1:0] faultSrc_reg;
  reg hardLatch0_reg;
  reg hardLatch1_reg;
  reg altState_reg;

  // ==========================================
  // input synchronisers
  reg [2:0] syncA_reg;
  reg [2:0] syncB_reg;
  wire matchSync;
  wire ev0Sync;
  wire ev1Sync;

  // pins come from other logic or other clocks, so two flops each
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      syncA_reg <= 3'h0;
      syncB_reg <= 3'h0;
    end else begin
      syncA_reg <= {timerEventIn1, timerEventIn0, matchEventIn};
      syncB_reg <= syncA_reg;
    end
  end

  // only the second flop of each chain is tapped; two cycles of fault
  // latency are the price of keeping metastability out of the filters
  assign matchSync = syncB_reg[0];
  assign ev0Sync = syncB_reg[1];
  assign ev1Sync = syncB_reg[2];

  // ==========================================
  // field views
  wire [7:0] dtHigh;
  wire [7:0] dtLow;
  wire [3:0] dtEnable;
  wire [1:0] routeSel;
  wire [3:0] filt0;
  wire [3:0] filt1;
  wire [7:0] invertEn;
  wire [7:0] faultLevel;
  wire [7:0] overrideEn;

  // named slices of the two configuration words
  assign dtHigh = waveform_extension_control_reg[`PDF_WEX_DEAD_TIME_HIGH_SIDE_MSB:`PDF_WEX_DEAD_TIME_HIGH_SIDE_LSB];
  assign dtLow = waveform_extension_control_reg[`PDF_WEX_DEAD_TIME_LOW_SIDE_MSB:`PDF_WEX_DEAD_TIME_LOW_SIDE_LSB];
  assign dtEnable = waveform_extension_control_reg[`PDF_WEX_DTEN_LSB +: 4];
  assign routeSel = waveform_extension_control_reg[`PDF_WEX_ROUTE_LSB +: 2];
  assign filt1 = output_driver_control_reg[`PDF_DRV_FLT1_LSB +: 4];
  assign filt0 = output_driver_control_reg[`PDF_DRV_FLT0_LSB +: 4];
  assign invertEn = output_driver_control_reg[`PDF_DRV_INV_LSB +: 8];
  assign faultLevel = output_driver_control_reg[`PDF_DRV_LVL_LSB +: 8];
  assign overrideEn = output_driver_control_reg[`PDF_DRV_OVR_LSB +: 8];

  // ==========================================
  // register writes
  wire wrCtrl;
  wire wrStat;
  wire wrCfg;

  // control and status stay writable while running, so software can
  // always stop the timer and clear a latched fault
  assign wrCtrl = regWrite && (regAddr == `PDF_CTRL_OFS);
  assign wrStat = regWrite && (regAddr == `PDF_STAT_OFS);
  // configuration is frozen while running so the outputs never see
  // a half-changed dead time or routing mid-period
  assign wrCfg = regWrite && !timerEnable;

  // control and configuration registers
  // a refused write is dropped silently; no error flag is raised
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      timerEnable <= 1'b0;
      waveform_extension_control_reg <= `PDF_WEX_RST;
      output_driver_control_reg <= `PDF_DRV_RST;
      faultSrc_reg <= 2'h0;
    end else begin
      if (wrCtrl) begin
        timerEnable <= regWdata[`PDF_CTRL_EN];
      end
      if (wrCfg && regAddr == `PDF_WEX_OFS) begin
        waveform_extension_control_reg <= regWdata & `PDF_WEX_MASK;
      end
      if (wrCfg && regAddr == `PDF_DRV_OFS) begin
        output_driver_control_reg <= regWdata & `PDF_DRV_MASK;
      end
      if (wrCfg && regAddr == `PDF_FSRC_OFS) begin
        faultSrc_reg <= regWdata[`PDF_FSRC_LSB +: 2];
      end
    end
  end

  // ==========================================
  // hard fault filters and sticky latches
  // each filter sees the synchronised pin, so its count is in clock cycles
  wire hardFilt0;
  wire hardFilt1;

  pdf_filter uFilt0 (
    .ref_clk(ref_clk),
    .rst(rst),
    .sampleIn(ev0Sync),
    .filterVal(filt0),
    .filtOut(hardFilt0)
  );

  pdf_filter uFilt1 (
    .ref_clk(ref_clk),
    .rst(rst),
    .sampleIn(ev1Sync),
    .filterVal(filt1),
    .filtOut(hardFilt1)
  );

  // faults stay latched until software writes one to clear;
  // a fault arriving in the clear cycle wins over the clear
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hardLatch0_reg <= 1'b0;
      hardLatch1_reg <= 1'b0;
    end else begin
      if (hardFilt0) begin
        hardLatch0_reg <= 1'b1;
      end else if (wrStat && regWdata[`PDF_STAT_HF0]) begin
        hardLatch0_reg <= 1'b0;
      end
      if (hardFilt1) begin
        hardLatch1_reg <= 1'b1;
      end else if (wrStat && regWdata[`PDF_STAT_HF1]) begin
        hardLatch1_reg <= 1'b0;
      end
    end
  end

  // limitation: the override is not gated by the enable bit, so a fault
  // seen while stopped still forces the pins until software clears it
  // one cycle of lag keeps the override on a flop output
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hardFault <= 1'b0;
    end else begin
      hardFault <= hardLatch0_reg | hardLatch1_reg | hardFilt0 | hardFilt1;
    end
  end

  // ==========================================
  // recoverable fault source
  reg softFault_next;

  // the alternate fault level is only sampled at period end
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      altState_reg <= 1'b0;
    end else if (periodEnd) begin
      altState_reg <= altFaultIn;
    end
  end

  // source select
  // code 3 is a period late by nature: it uses the state from the last period end
  always @* begin
    case (faultSrc_reg)
      `PDF_SRC_OFF: softFault_next = 1'b0;
      `PDF_SRC_DIRECT: softFault_next = matchSync;
      `PDF_SRC_INVERT: softFault_next = !matchSync;
      `PDF_SRC_ALT: softFault_next = altState_reg;
      default: softFault_next = 1'b0;
    endcase
  end

  // the fault only counts while the timer runs,
  // so a stopped timer never reports a stale recoverable fault
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      softFault <= 1'b0;
    end else begin
      softFault <= softFault_next && timerEnable;
    end
  end

  // ==========================================
  // output matrix
  reg [7:0] matrix_next;

  // four fixed routings of the compare signals onto eight outputs
  // the table is fixed in logic; software only picks one of four rows
  always @* begin
    case (routeSel)
      2'h0: matrix_next = {compareIn, compareIn};
      2'h1: matrix_next = {4{compareIn[1:0]}};
      2'h2: matrix_next = {8{compareIn[0]}};
      2'h3: matrix_next = {{7{compareIn[1]}}, compareIn[0]};
      default: matrix_next = 8'h00;
    endcase
  end

  // ==========================================
  // dead-time generators
  reg [7:0] dtOut;
  reg [3:0] lastLvl_reg;
  reg [3:0] lowSide_reg;
  reg [3:0] highSide_reg;
  reg [31:0] dtCnt_reg;

  // limitation: a source pulse shorter than its dead time restarts the
  // count, so it never reaches the side it would turn on, though both sides still drop
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : gDead
      // an edge of the source drops both sides, then the side that
      // is turning on waits out its own dead time before rising
      always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          lastLvl_reg[gi] <= 1'b0;
          lowSide_reg[gi] <= 1'b0;
          highSide_reg[gi] <= 1'b0;
          dtCnt_reg[gi*8 +: 8] <= 8'h00;
        end else if (matrix_next[gi] != lastLvl_reg[gi]) begin
          lastLvl_reg[gi] <= matrix_next[gi];
          lowSide_reg[gi] <= 1'b0;
          highSide_reg[gi] <= 1'b0;
          if (matrix_next[gi]) begin
            dtCnt_reg[gi*8 +: 8] <= dtLow;
          end else begin
            dtCnt_reg[gi*8 +: 8] <= dtHigh;
          end
        end else if (dtCnt_reg[gi*8 +: 8] != 8'h00) begin
          dtCnt_reg[gi*8 +: 8] <= dtCnt_reg[gi*8 +: 8] - 8'h01;
        end else begin
          lowSide_reg[gi] <= lastLvl_reg[gi];
          highSide_reg[gi] <= !lastLvl_reg[gi];
        end
      end
    end
  endgenerate

  // enabled generators take over outputs x and x+4
  integer di;
  always @* begin
    dtOut = matrix_next;
    for (di = 0; di < 4; di = di + 1) begin
      if (dtEnable[di]) begin
        dtOut[di] = lowSide_reg[di];
        dtOut[di+4] = highSide_reg[di];
      end
    end
  end

  // ==========================================
  // inversion and hard fault override
  reg [7:0] wave_next;
  integer oi;

  // override sits after inversion so the forced level is absolute
  always @* begin
    wave_next = dtOut ^ invertEn;
    for (oi = 0; oi < 8; oi = oi + 1) begin
      if (hardFault && overrideEn[oi]) begin
        wave_next[oi] = faultLevel[oi];
      end
    end
  end

  // the pins change only on the clock edge, never straight from the matrix
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      waveOut <= 8'h00;
    end else begin
      waveOut <= wave_next;
    end
  end

  // ==========================================
  // register reads
  reg [31:0] rd_next;

  // unmapped offsets read as zero
  // status bits are live views, so a read never clears anything
  always @* begin
    rd_next = 32'h00000000;
    case (regAddr)
      `PDF_CTRL_OFS: rd_next[`PDF_CTRL_EN] = timerEnable;
      `PDF_STAT_OFS: begin
        rd_next[`PDF_STAT_HF0] = hardLatch0_reg;
        rd_next[`PDF_STAT_HF1] = hardLatch1_reg;
        rd_next[`PDF_STAT_RF] = softFault;
        rd_next[`PDF_STAT_ALT] = altState_reg;
        rd_next[`PDF_STAT_EN] = timerEnable;
      end
      `PDF_FSRC_OFS: rd_next[`PDF_FSRC_LSB +: 2] = faultSrc_reg;
      `PDF_WEX_OFS: rd_next = waveform_extension_control_reg;
      `PDF_DRV_OFS: rd_next = output_driver_control_reg;
      default: rd_next = 32'h00000000;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      regRdata <= 32'h00000000;
    end else if (regRead) begin
      regRdata <= rd_next;
    end else begin
      regRdata <= 32'h00000000;
    end
  end
endmodule
`default_nettype wire

// ### pdf_driver_checker.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// port checker for the driver stage
module pdf_driver_checker (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [31:0] regRdata,
  input wire logic [3:0] compareIn,
  input wire logic periodEnd,
  input wire logic matchEventIn,
  input wire logic altFaultIn,
  input wire logic timerEventIn0,
  input wire logic timerEventIn1,
  input wire logic [7:0] waveOut,
  input wire logic softFault,
  input wire logic hardFault,
  input wire logic timerEnable
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [31:0] wexReg;
  logic [31:0] drvReg;
  // shadows honour the run lock, so a leaky lock shows up on readback
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wexReg <= 32'h0;
      drvReg <= 32'h0;
    end else if (regWrite && !timerEnable) begin
      if (regAddr == 8'h14) wexReg <= regWdata & 32'hFFFF0F03;
      if (regAddr == 8'h18) drvReg <= regWdata;
    end
  end
  // ==========================================
  // assertions
  AST_RD_IDLE: assert property (!$past(regRead) |-> regRdata == 32'h0)
    else $error("read data not zero outside a read");
  AST_RD_WEX: assert property (regRead && regAddr == 8'h14 |=> regRdata == $past(wexReg))
    else $error("dead time register readback wrong");
  AST_RD_DRV: assert property (regRead && regAddr == 8'h18 |=> regRdata == $past(drvReg))
    else $error("driver register readback wrong");
  AST_EN_WR: assert property (regWrite && regAddr == 8'h00 |=> timerEnable == $past(regWdata[0]))
    else $error("enable bit not written");
  AST_HF_CAUSE: assert property ($rose(hardFault) |-> $past(timerEventIn0 | timerEventIn1, 4))
    else $error("hard fault without an event");
  AST_HF_OVR: assert property ($past(hardFault) && $stable(drvReg)
    |-> ((waveOut ^ drvReg[15:8]) & drvReg[7:0]) == 8'h0)
    else $error("override level not driven");
  AST_DT_GAP: assert property (wexReg[8] && (drvReg & 32'h00110011) == 32'h0 && !hardFault
    && !$past(hardFault) && $stable(wexReg) && $stable(drvReg)
    |-> !(waveOut[0] && waveOut[4]))
    else $error("both sides of a pair high");
  AST_SOFT_EN: assert property (!timerEnable && !$past(timerEnable) |-> !softFault)
    else $error("soft fault while stopped");
  cover property ($rose(hardFault));
  cover property ($rose(softFault));
  cover property ($fell(waveOut[4]) ##[1:20] $rose(waveOut[0]));
endmodule
`default_nettype wire

// ### pdf_driver_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "pdf_regs.vh"
module pdf_driver_tb;
  logic ref_clk, rst, regWrite, regRead, periodEnd, matchEventIn, altFaultIn;
  logic timerEventIn0, timerEventIn1, softFault, hardFault, timerEnable, rdPend, e;
  logic [7:0] regAddr, waveOut, seed;
  logic [31:0] regWdata, regRdata, d;
  logic [3:0] compareIn;
  logic [31:0] expQ[$];
  int errors, tests_run, cyc, tr, tf;
  pdf_driver DUT (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .compareIn(compareIn),
    .periodEnd(periodEnd), .matchEventIn(matchEventIn), .altFaultIn(altFaultIn),
    .timerEventIn0(timerEventIn0), .timerEventIn1(timerEventIn1), .waveOut(waveOut),
    .softFault(softFault), .hardFault(hardFault), .timerEnable(timerEnable));
  // ==========================================
  // helpers
  function automatic [7:0] nx();
    seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
    return seed;
  endfunction
  function automatic [7:0] route(input [1:0] r, input [3:0] c);
    case (r)
      2'h0: route = {c, c};
      2'h1: route = {4{c[1:0]}};
      2'h2: route = {8{c[0]}};
      default: route = {{7{c[1]}}, c[0]};
    endcase
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("FAIL t=%0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // one compare task per kind of result, all through the common core
  task automatic chkRd(input logic [31:0] got, input logic [31:0] exp);
    chk(got, exp, "read data");
  endtask
  task automatic chkWave(input logic [7:0] got, input logic [7:0] exp);
    chk({24'h0, got}, {24'h0, exp}, "wave outputs");
  endtask
  task automatic chkFlag(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp}, "fault flag");
  endtask
  task automatic chkTime(input int got, input int exp);
    chk(got, exp, "dead time");
  endtask
  task wr(input [7:0] a, input [31:0] v);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= v;
    regWrite <= 1'h1;
    @(posedge ref_clk);
    regWrite <= 1'h0;
  endtask
  // the expected word is queued before the strobe so the watcher never runs dry
  task rd(input [7:0] a, input [31:0] v);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'h1;
    expQ.push_back(v);
    @(posedge ref_clk);
    regRead <= 1'h0;
  endtask
  // bounded wait for one output bit to go high
  task wt(input int b, output int t);
    t = 0;
    while (waveOut[b] !== 1'h1 && t < 60) begin
      @(posedge ref_clk);
      t++;
    end
  endtask
  task summarize();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========================================
  // clock, read watcher and hang guard
  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    rdPend <= regRead;
    if (rdPend === 1'h1) chkRd(regRdata, expQ.pop_front());
    cyc++;
    if (cyc == 4000) begin
      errors++;
      summarize();
    end
  end
  // ==========================================
  // main sequence
  initial begin
    {regWrite, regRead, periodEnd, matchEventIn, altFaultIn} = 5'h0;
    {timerEventIn0, timerEventIn1} = 2'h0;
    regAddr = 8'h0;
    regWdata = 32'h0;
    compareIn = 4'h0;
    seed = 8'h4A;
    rst = 1'h1;
    repeat (12) @(posedge ref_clk);
    rst <= 1'h0;
    rd(8'h14, 32'h0);
    rd(8'h18, 32'h0);
    rd(8'h40, 32'h0);
    // random words survive only in the implemented bits
    repeat (3) begin
      d = {nx(), nx(), nx(), nx()};
      wr(8'h14, d);
      rd(8'h14, d & `PDF_WEX_MASK);
      wr(8'h18, d);
      rd(8'h18, d);
    end
    for (int i = 0; i < 4; i++) begin
      d = {nx(), nx(), nx(), nx()};
      wr(8'h18, {8'h0, d[23:16], 16'h0});
      wr(8'h14, {30'h0, i[1:0]});
      compareIn <= d[3:0];
      repeat (6) @(posedge ref_clk);
      chkWave(waveOut ^ d[23:16], route(i[1:0], d[3:0]));
    end
    // dead time: low side 3, high side 9, only generator 0 on
    compareIn <= 4'h0;
    wr(8'h18, 32'h0);
    wr(8'h14, 32'h09030100);
    repeat (20) @(posedge ref_clk);
    compareIn <= 4'h1;
    wt(0, tr);
    compareIn <= 4'h0;
    wt(4, tf);
    chkTime(tr + 9, tf + 3);
    // configuration is frozen while running, the enable bit is not
    wr(8'h00, 32'h1);
    wr(8'h14, 32'hFFFFFFFF);
    rd(8'h14, 32'h09030100);
    wr(8'h00, 32'h0);
    rd(8'h00, 32'h0);
    for (int i = 0; i < 8; i++) begin
      d = {24'h0, nx()};
      wr(8'h0C, {30'h0, i[1:0]});
      wr(8'h00, 32'h1);
      matchEventIn <= d[0]; // the event passes the two synchroniser flops before it counts
      altFaultIn <= d[1];
      periodEnd <= 1'h1;
      @(posedge ref_clk);
      periodEnd <= 1'h0;
      repeat (6) @(posedge ref_clk);
      e = (i[1:0] == 2'h0) ? 1'h0 : (i[1:0] == 2'h1) ? d[0] : (i[1:0] == 2'h2) ? ~d[0] : d[1];
      chkFlag(softFault, e);
      wr(8'h00, 32'h0);
    end
    // filter of 6 on input 0: five samples too few, six enough
    wr(8'h18, 32'h0600A5F0);
    timerEventIn0 <= 1'h1;
    repeat (5) @(posedge ref_clk);
    timerEventIn0 <= 1'h0;
    repeat (12) @(posedge ref_clk);
    chkFlag(hardFault, 1'h0);
    timerEventIn0 <= 1'h1;
    repeat (6) @(posedge ref_clk);
    timerEventIn0 <= 1'h0;
    repeat (12) @(posedge ref_clk);
    chkFlag(hardFault, 1'h1);
    chkWave(waveOut, 8'hA0);
    wr(8'h04, 32'h3);
    repeat (4) @(posedge ref_clk);
    chkFlag(hardFault, 1'h0);
    // filter 1 stays at zero, so a one-cycle synchronous event counts at once
    timerEventIn1 <= 1'h1;
    @(posedge ref_clk);
    timerEventIn1 <= 1'h0;
    repeat (8) @(posedge ref_clk);
    chkFlag(hardFault, 1'h1);
    // only the second latch is left; the alternate state is the last one latched
    rd(8'h04, {28'h0, d[1], 3'h2});
    repeat (2) @(posedge ref_clk);
    summarize();
  end
endmodule
bind pdf_driver pdf_driver_checker u_chk (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr),
  .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
  .compareIn(compareIn), .periodEnd(periodEnd), .matchEventIn(matchEventIn),
  .altFaultIn(altFaultIn), .timerEventIn0(timerEventIn0), .timerEventIn1(timerEventIn1),
  .waveOut(waveOut), .softFault(softFault), .hardFault(hardFault), .timerEnable(timerEnable));
`default_nettype wire
